// ===== rtl/preview_table_regs.svh
`ifndef PREVIEW_TABLE_REGS_SVH
`define PREVIEW_TABLE_REGS_SVH

// register byte addresses on the host port
`define OFS_TABLE_INDEX 8'h00
`define OFS_TABLE_DATA 8'h04
`define OFS_ENGINE_CTRL 8'h08
`define OFS_ENGINE_STATUS 8'h0c

// engine control and status fields
`define BIT_ENGINE_ENABLE 0
`define BIT_SINGLE_FRAME 1
`define BIT_BUSY_FLAG 0

// widths
`define ADDR_W 8
`define DATA_W 32
`define INDEX_W 13
`define ENTRY_W 20
`define NARROW_W 8

// unified table index space: first and last entry of each memory
`define GAMMA_FIRST 13'h0000
`define GAMMA_LAST 13'h0bff
`define NF_FIRST 13'h0c00
`define NF_LAST 13'h0cff
`define ENH_FIRST 13'h1000
`define ENH_LAST 13'h107f
`define CFA_FIRST 13'h1400
`define CFA_LAST 13'h16f7

// entry counts
`define GAMMA_DEPTH 3072
`define NF_DEPTH 256
`define ENH_DEPTH 128
`define CFA_DEPTH 760

// reset values and index step
`define INDEX_RESET 13'h0000
`define ENTRY_ZERO 20'h00000
`define WORD_ZERO 32'h0000_0000
`define INDEX_STEP 13'h0001

`endif

// ===== rtl/preview_table_pkg.sv
package preview_table_pkg;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} host_req_t;

	typedef enum logic [2:0] {
		SEL_NONE = 3'b000,
		SEL_GAMMA = 3'b001,
		SEL_NF = 3'b010,
		SEL_ENH = 3'b011,
		SEL_CFA = 3'b100
	} table_sel_t;

	typedef struct packed {
		logic engine_enable;
		logic single_frame_mode;
		logic busy_flag;
	} engine_state_t;

endpackage

// ===== rtl/preview_table_access.sv
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "preview_table_regs.svh"
// Overview of operation
// RQ1: reset returns control registers to defaults; table memories have no reset.
// RQ2: table contents survive a module reset; undefined after power-up until loaded.
// RQ3: software programs all base settings before setting the enable bit.
// RQ4: software programs dependent settings for each enabled option or port.
// RQ5: software loads every table whose function is enabled before processing.
// RQ6: one index register selects an entry; a data register reads or writes it.
// RQ7: data register is 20 bits; 8-bit tables use only the low byte.
// RQ8: index space ends at 3FF,7FF,BFF,CFF,107F and 16F7 for the six tables.
// RQ9: every data register read or write advances the index by one.
// RQ10: software rewrites the index before each non-sequential access.
// RQ11: while busy, data register accesses leave the index unchanged.
// RQ12: coefficient table starts at index 0x1400.
// RQ13: data register reads while busy give indeterminate data.
// RQ14: busy sets at frame start with enable high; clears when safe.
// RQ15: out-of-range index: writes do nothing, reads return zero.
// RQ16: writes store only the bits the addressed memory implements.
module preview_table_access
	import preview_table_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic ce,
	input wire host_req_t req,
	input wire logic frame_start,
	input wire logic frame_safe,
	output logic [`DATA_W-1:0] rdata_r,
	output engine_state_t state_r,
	output logic [`INDEX_W-1:0] index_r
);

	function automatic table_sel_t decode_sel(input logic [`INDEX_W-1:0] idx);
		table_sel_t s;
		s = SEL_NONE;
		if (idx <= `GAMMA_LAST) begin
			s = SEL_GAMMA;
		end else if (idx >= `NF_FIRST && idx <= `NF_LAST) begin
			s = SEL_NF;
		end else if (idx >= `ENH_FIRST && idx <= `ENH_LAST) begin
			s = SEL_ENH;
		end else if (idx >= `CFA_FIRST && idx <= `CFA_LAST) begin
			s = SEL_CFA;
		end
		return s;
	endfunction

	// tables held in plain flops without reset so a module reset keeps them
	logic [`NARROW_W-1:0] gamma_mem [`GAMMA_DEPTH];
	logic [`NARROW_W-1:0] nf_mem [`NF_DEPTH];
	logic [`ENTRY_W-1:0] enh_mem [`ENH_DEPTH];
	logic [`NARROW_W-1:0] cfa_mem [`CFA_DEPTH];

	table_sel_t sel;
	logic data_wr;
	logic data_rd;
	logic [`INDEX_W-1:0] gamma_ofs;
	logic [`INDEX_W-1:0] nf_ofs;
	logic [`INDEX_W-1:0] enh_ofs;
	logic [`INDEX_W-1:0] cfa_ofs;
	logic [`ENTRY_W-1:0] entry_rd;
	logic [`INDEX_W-1:0] index_nxt;
	logic [`DATA_W-1:0] rdata_nxt;
	logic engine_enable_r;
	logic single_frame_mode_r;
	logic busy_flag_r;

	assign sel = decode_sel(index_r); // [RQ8]
	assign data_wr = req.wr && req.addr == `OFS_TABLE_DATA;
	assign data_rd = req.rd && req.addr == `OFS_TABLE_DATA;
	assign gamma_ofs = index_r - `GAMMA_FIRST;
	assign nf_ofs = index_r - `NF_FIRST;
	assign enh_ofs = index_r - `ENH_FIRST;
	assign cfa_ofs = index_r - `CFA_FIRST; // [RQ12]

	// one flop per field, so each field has a single driving process
	assign state_r = '{engine_enable: engine_enable_r,
		single_frame_mode: single_frame_mode_r, busy_flag: busy_flag_r};

	always_comb begin
		entry_rd = `ENTRY_ZERO;
		unique case (sel)
			SEL_GAMMA: entry_rd = {12'h000, gamma_mem[gamma_ofs[11:0]]}; // [RQ7]
			SEL_NF: entry_rd = {12'h000, nf_mem[nf_ofs[7:0]]};
			SEL_ENH: entry_rd = enh_mem[enh_ofs[6:0]];
			SEL_CFA: entry_rd = {12'h000, cfa_mem[cfa_ofs[9:0]]};
			SEL_NONE: entry_rd = `ENTRY_ZERO; // [RQ15]
		endcase
	end

	// table writes: only implemented bits are kept, out-of-range goes nowhere
	always_ff @(posedge clock) begin
		if (ce && data_wr) begin
			unique case (sel)
				SEL_GAMMA: gamma_mem[gamma_ofs[11:0]] <= req.wdata[`NARROW_W-1:0]; // [RQ16] [RQ1]
				SEL_NF: nf_mem[nf_ofs[7:0]] <= req.wdata[`NARROW_W-1:0]; // [RQ16]
				SEL_ENH: enh_mem[enh_ofs[6:0]] <= req.wdata[`ENTRY_W-1:0]; // [RQ7]
				SEL_CFA: cfa_mem[cfa_ofs[9:0]] <= req.wdata[`NARROW_W-1:0]; // [RQ2]
				SEL_NONE: ; // [RQ15]
			endcase
		end
	end

	// index: host write wins over auto-advance; advance frozen while busy
	always_comb begin
		index_nxt = index_r;
		if (req.wr && req.addr == `OFS_TABLE_INDEX) begin
			index_nxt = req.wdata[`INDEX_W-1:0];
		end else if ((data_wr || data_rd) && !state_r.busy_flag) begin // [RQ11]
			index_nxt = index_r + `INDEX_STEP; // [RQ9]
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			index_r <= `INDEX_RESET; // [RQ1]
		end else if (ce) begin
			index_r <= index_nxt; // [RQ6]
		end
	end

	// enable and one-shot: a one-shot frame start drops enable, ahead of a host write in the same cycle
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			engine_enable_r <= 1'b0; // [RQ1]
			single_frame_mode_r <= 1'b0;
		end else if (ce) begin
			if (frame_start && engine_enable_r && single_frame_mode_r) begin
				engine_enable_r <= 1'b0;
				single_frame_mode_r <= 1'b0;
			end else if (req.wr && req.addr == `OFS_ENGINE_CTRL) begin
				engine_enable_r <= req.wdata[`BIT_ENGINE_ENABLE];
				single_frame_mode_r <= req.wdata[`BIT_SINGLE_FRAME];
			end
		end
	end

	// busy: a start with enable high in the same cycle as the safe pulse keeps busy set
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			busy_flag_r <= 1'b0; // [RQ1]
		end else if (ce) begin
			if (frame_start && engine_enable_r) begin
				busy_flag_r <= 1'b1; // [RQ14]
			end else if (frame_safe) begin
				busy_flag_r <= 1'b0; // [RQ14]
			end
		end
	end

	// read data valid only in the cycle after the strobe, zero otherwise
	always_comb begin
		rdata_nxt = `WORD_ZERO;
		if (req.rd) begin
			unique case (req.addr)
				`OFS_TABLE_INDEX: rdata_nxt = {19'h00000, index_r};
				`OFS_TABLE_DATA: begin
					// memories belong to the datapath while busy; give zero
					if (!state_r.busy_flag) begin // [RQ13]
						rdata_nxt = {12'h000, entry_rd};
					end
				end
				`OFS_ENGINE_CTRL: begin
					rdata_nxt[`BIT_ENGINE_ENABLE] = state_r.engine_enable;
					rdata_nxt[`BIT_SINGLE_FRAME] = state_r.single_frame_mode;
				end
				`OFS_ENGINE_STATUS: rdata_nxt[`BIT_BUSY_FLAG] = state_r.busy_flag;
				default: rdata_nxt = `WORD_ZERO;
			endcase
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rdata_r <= `WORD_ZERO;
		end else if (ce) begin
			rdata_r <= rdata_nxt;
		end
	end

	a_index_advance: assert property (@(posedge clock) disable iff (!arst_n) // [RQ9]
		ce && (data_rd || data_wr) && !state_r.busy_flag
		|=> index_r == $past(index_r) + `INDEX_STEP)
		else $error("table index did not advance on data access");

	// index must not creep when nothing that addresses it is taken
	a_index_idle_hold: assert property (@(posedge clock) disable iff (!arst_n) // [RQ9]
		!ce || !(data_wr || data_rd || req.wr && req.addr == `OFS_TABLE_INDEX)
		|=> $stable(index_r))
		else $error("table index moved without an access");

	a_index_busy_hold: assert property (@(posedge clock) disable iff (!arst_n) // [RQ11]
		ce && (data_rd || data_wr) && state_r.busy_flag
		|=> $stable(index_r))
		else $error("table index moved during busy access");

	a_busy_read_zero: assert property (@(posedge clock) disable iff (!arst_n) // [RQ13]
		ce && data_rd && state_r.busy_flag |=> rdata_r == `WORD_ZERO)
		else $error("busy table read returned data");

	a_busy_on_start: assert property (@(posedge clock) disable iff (!arst_n) // [RQ14]
		ce && frame_start && state_r.engine_enable |=> state_r.busy_flag)
		else $error("busy not set at frame start");

	a_busy_clear_safe: assert property (@(posedge clock) disable iff (!arst_n) // [RQ14]
		ce && frame_safe && !frame_start |=> !state_r.busy_flag)
		else $error("busy not cleared when safe");

	a_busy_idle_hold: assert property (@(posedge clock) disable iff (!arst_n) // [RQ14]
		!(ce && (frame_start || frame_safe)) |=> $stable(busy_flag_r))
		else $error("busy changed without a frame event");

	a_oob_read_zero: assert property (@(posedge clock) disable iff (!arst_n) // [RQ15]
		ce && data_rd && (index_r > `NF_LAST && index_r < `ENH_FIRST
		|| index_r > `ENH_LAST && index_r < `CFA_FIRST || index_r > `CFA_LAST)
		|=> rdata_r == `WORD_ZERO)
		else $error("out-of-range table read not zero");

	a_narrow_upper_zero: assert property (@(posedge clock) disable iff (!arst_n) // [RQ7]
		ce && data_rd && (index_r <= `NF_LAST || index_r >= `CFA_FIRST)
		|=> rdata_r[`DATA_W-1:`NARROW_W] == '0)
		else $error("narrow table read has upper bits");

	a_index_readback: assert property (@(posedge clock) disable iff (!arst_n) // [RQ6]
		ce && req.wr && req.addr == `OFS_TABLE_INDEX
		##1 ce && req.rd && req.addr == `OFS_TABLE_INDEX
		|=> rdata_r[`INDEX_W-1:0] == $past(req.wdata[`INDEX_W-1:0], 2))
		else $error("index readback mismatch");

endmodule

// ===== bench/preview_table_access_tb.sv
`timescale 1ns/1ps
`include "preview_table_regs.svh"
module preview_table_access_tb
	import preview_table_pkg::*;
;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic ce = 1'b1;
	logic frame_start = 1'b0;
	logic frame_safe = 1'b0;
	host_req_t req = '0;
	logic [31:0] rdata_r;
	engine_state_t state_r;
	logic [12:0] index_r;
	logic [31:0] d;
	logic [31:0] ix;
	logic bz;
	int err_count = 0;
	int comparisons = 0;
	int cyc = 0;
	logic [12:0] ends [6] = '{13'h03ff, 13'h07ff, 13'h0bff, 13'h0cff, 13'h107f, 13'h16f7};

	preview_table_access u_preview_table_access (.clock(clock), .arst_n(arst_n), .ce(ce),
		.req(req), .frame_start(frame_start), .frame_safe(frame_safe), .rdata_r(rdata_r),
		.state_r(state_r), .index_r(index_r));

	initial forever #2 clock = ~clock;

	task give_verdict;
		$display("comparisons %0d errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ceiling well above the roughly 140 cycles the run needs
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_count = err_count + 1;
			give_verdict();
		end
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons = comparisons + 1;
		if (seen !== exp) begin
			err_count = err_count + 1;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one access, then an idle cycle so strobes are never reassigned in one step
	task acc(input logic [7:0] a, input logic [31:0] v, input logic rd);
		req <= {a, v, !rd, rd};
		@(posedge clock);
		req.wr <= 1'b0;
		req.rd <= 1'b0;
		@(negedge clock);
		d = rdata_r;
		ix = 32'(index_r);
		@(posedge clock);
	endtask

	task pulse(input logic safe);
		frame_start <= !safe;
		frame_safe <= safe;
		@(posedge clock);
		frame_start <= 1'b0;
		frame_safe <= 1'b0;
		@(negedge clock);
		bz = state_r.busy_flag;
		@(posedge clock);
	endtask

	task t_walk;
		acc(`OFS_TABLE_INDEX, 32'h1400, 1'b0);
		chk(ix, 32'h1400);
		acc(`OFS_TABLE_DATA, 32'h0a5, 1'b0);
		chk(ix, 32'h1401);
		acc(`OFS_TABLE_DATA, 32'h05a, 1'b0);
		acc(`OFS_TABLE_INDEX, 32'h1400, 1'b0);
		acc(`OFS_TABLE_DATA, 32'h0, 1'b1);
		chk(d, 32'h0a5);
		chk(ix, 32'h1401);
		acc(`OFS_TABLE_DATA, 32'h0, 1'b1);
		chk(d, 32'h05a);
	endtask

	// last entry of every memory; upper data bits must be dropped
	task t_ends;
		for (int i = 0; i < 6; i++) begin
			acc(`OFS_TABLE_INDEX, 32'(ends[i]), 1'b0);
			acc(`OFS_TABLE_DATA, 32'h0fabcde, 1'b0);
			acc(`OFS_TABLE_INDEX, 32'(ends[i]), 1'b0);
			acc(`OFS_TABLE_DATA, 32'h0, 1'b1);
			chk(d, (i == 4) ? 32'habcde : 32'h0de);
			chk(ix, 32'(ends[i] + 13'h0001));
		end
		acc(`OFS_TABLE_INDEX, 32'h0d00, 1'b0);
		acc(`OFS_TABLE_DATA, 32'h055, 1'b0);
		acc(`OFS_TABLE_INDEX, 32'h0d00, 1'b0);
		acc(`OFS_TABLE_DATA, 32'h0, 1'b1);
		chk(d, 32'h0);
		acc(8'h10, 32'h1, 1'b0);
		acc(8'h10, 32'h0, 1'b1);
		chk(d, 32'h0);
	endtask

	task t_busy;
		acc(`OFS_TABLE_INDEX, 32'h1000, 1'b0);
		acc(`OFS_ENGINE_CTRL, 32'h1, 1'b0);
		pulse(1'b0);
		chk(32'(bz), 32'h1);
		acc(`OFS_TABLE_DATA, 32'h0, 1'b1);
		chk(d, 32'h0);
		chk(ix, 32'h1000);
		pulse(1'b1);
		chk(32'(bz), 32'h0);
		acc(`OFS_ENGINE_CTRL, 32'h0, 1'b0);
	endtask

	// back-to-back strobes, control and status readback, one-shot, frozen enable
	task t_modes;
		req <= {`OFS_TABLE_INDEX, 32'h1400, 1'b1, 1'b0};
		@(posedge clock);
		acc(`OFS_TABLE_INDEX, 32'h0, 1'b1);
		chk(d, 32'h1400);
		acc(`OFS_ENGINE_CTRL, 32'h3, 1'b0);
		acc(`OFS_ENGINE_CTRL, 32'h0, 1'b1);
		chk(d, 32'h3);
		pulse(1'b0);
		chk(32'(bz), 32'h1);
		acc(`OFS_ENGINE_CTRL, 32'h0, 1'b1);
		chk(d, 32'h0);
		acc(`OFS_ENGINE_STATUS, 32'h0, 1'b1);
		chk(d, 32'h1);
		pulse(1'b1);
		acc(`OFS_ENGINE_STATUS, 32'h0, 1'b1);
		chk(d, 32'h0);
		ce <= 1'b0;
		acc(`OFS_TABLE_DATA, 32'h33, 1'b0);
		ce <= 1'b1;
		chk(ix, 32'h1400);
		acc(`OFS_TABLE_DATA, 32'h0, 1'b1);
		chk(d, 32'h0a5);
	endtask

	// mid-run reset: registers clear, table contents stay
	task t_retain;
		acc(`OFS_ENGINE_CTRL, 32'h1, 1'b0);
		arst_n <= 1'b0;
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		@(negedge clock);
		chk(32'(index_r), 32'h0);
		chk(32'(state_r), 32'h0);
		@(posedge clock);
		acc(`OFS_TABLE_INDEX, 32'h16f7, 1'b0);
		acc(`OFS_TABLE_DATA, 32'h0, 1'b1);
		chk(d, 32'h0de);
	endtask

	initial begin
		repeat (20) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		t_walk();
		t_ends();
		t_busy();
		t_modes();
		t_retain();
		give_verdict();
	end
endmodule
